// file: src/mcis_pkg.sv
/*
 * shared constants, types and the instruction decoder for the
 * instruction subset core.
 * assumes: 12-bit instruction words, one sys_clk per instruction cycle.
 */
package mcis_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int unsigned INSTR_W     = 12;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned PC_W        = 11;
	localparam int unsigned FILE_DEPTH  = 32;
	localparam int unsigned FADDR_W     = 5;
	localparam int unsigned STACK_DEPTH = 2;

	// ----------------------------------------------------------------
	// status bit positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned STAT_NULL_BIT   = 2;
	localparam int unsigned STAT_SLEEP_BIT  = 3;
	localparam int unsigned STAT_EXPIRY_BIT = 4;
	localparam int unsigned STAT_PAGE_LO    = 5;
	localparam int unsigned STAT_PAGE_HI    = 6;
	localparam logic [7:0]  STATUS_RESET    = 8'h18;
	localparam logic [7:0]  DATA_ZERO       = 8'h00;
	localparam logic [10:0] PC_RESET        = 11'h000;

	// ----------------------------------------------------------------
	// opcode fields
	// ----------------------------------------------------------------
	localparam logic [5:0]  OPC_AND_FILE  = 6'h05;
	localparam logic [6:0]  OPC_CLR_FILE  = 7'h03;
	localparam logic [3:0]  OPC_TEST_CLR  = 4'h6;
	localparam logic [3:0]  OPC_TEST_SET  = 4'h7;
	localparam logic [3:0]  OPC_CALL      = 4'h9;
	localparam logic [11:0] OPC_CLR_ACC   = 12'h040;
	localparam logic [11:0] OPC_CLR_WATCH = 12'h004;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_ACC       = 8'h08;
	localparam logic [7:0] REG_PC        = 8'h0c;
	localparam logic [7:0] REG_WATCH     = 8'h10;
	localparam logic [7:0] REG_FILE_BASE = 8'h80;
	localparam int unsigned CTRL_RUN_BIT = 0;
	localparam int unsigned CTRL_PSA_BIT = 1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP, OP_AND_FILE, OP_TEST_CLR, OP_TEST_SET,
		OP_CLR_ACC, OP_CLR_FILE, OP_CALL, OP_CLR_WATCH
	} mcis_op_t;

	typedef enum logic [1:0] {ST_EXEC, ST_SKIP, ST_BRANCH} mcis_state_t;

	typedef struct packed {
		mcis_op_t    op;
		logic        dest;
		logic [4:0]  fileAddr;
		logic [2:0]  bitSel;
		logic [7:0]  literal;
	} mcis_dec_t;

	// splits an instruction word into operation and operands
	function automatic mcis_dec_t mcis_decode(input logic [11:0] w);
		mcis_dec_t d;
		d.op       = OP_NOP;
		d.dest     = w[5];
		d.fileAddr = w[4:0];
		d.bitSel   = w[7:5];
		d.literal  = w[7:0];
		if (w[11:6] == OPC_AND_FILE)
			d.op = OP_AND_FILE;
		else if (w[11:5] == OPC_CLR_FILE)
			d.op = OP_CLR_FILE;
		else if (w[11:8] == OPC_TEST_CLR)
			d.op = OP_TEST_CLR;
		else if (w[11:8] == OPC_TEST_SET)
			d.op = OP_TEST_SET;
		else if (w[11:8] == OPC_CALL)
			d.op = OP_CALL;
		else if (w == OPC_CLR_ACC)
			d.op = OP_CLR_ACC;
		else if (w == OPC_CLR_WATCH)
			d.op = OP_CLR_WATCH;
		return d;
	endfunction

endpackage

// file: src/mcis_core.sv
/*
 * execute logic of a small 8-bit core for a subset of instructions,
 * with its file registers, accumulator, status, stack and watchdog count.
 * assumes: program memory returns the word at fetchAddr in the same
 * cycle from sys_clk logic; software reaches state over Avalon-MM.
 */
// What this block does
// - and accumulator with file, null flag only
// - destination bit picks accumulator or file
// - skip next when tested bit is clear
// - skip flushes fetched word, two cycles
// - skip when set; tests keep flags
// - clear accumulator, set null flag
// - clear file register, set null flag
// - call pushes pc plus one first
// - call loads literal and page bits
// - call clears pc bit eight, two cycles
// - watchdog clear, prescaler if assigned
// - watchdog clear sets expiry, sleep flags
module mcis_core (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	output logic [10:0]      fetchAddr,
	input  wire logic [11:0] instrWord,
	output logic             wdtClearPulse,
	output logic             prescalerClearPulse,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]              fileMem [mcis_pkg::FILE_DEPTH];
	logic [10:0]             stack_reg [mcis_pkg::STACK_DEPTH];
	logic [7:0]              accumulator_reg;
	logic [7:0]              accumulator_next;
	logic [7:0]              status_reg;
	logic [7:0]              status_next;
	logic [10:0]             pc_reg;
	logic [10:0]             pc_next;
	mcis_pkg::mcis_state_t   state_reg;
	mcis_pkg::mcis_state_t   state_next;
	logic [7:0]              watchdogCounter_reg;
	logic                    runEnable_reg;
	logic                    psaToWdt_reg;
	logic                    ackPhase_reg;
	logic [31:0]             readData_reg;
	logic                    wdtClear_reg;
	logic                    prescalerClear_reg;

	mcis_pkg::mcis_dec_t     dec;
	logic                    isExec;
	logic [7:0]              fileRead;
	logic                    bitVal;
	logic [7:0]              andResult;
	logic                    fileWrEn;
	logic [7:0]              fileWrData;
	logic                    pushEn;
	logic                    watchClear;
	logic                    busAccept;
	logic                    busWrite;
	logic                    swFileWr;

	// ----------------------------------------------------------------
	// decode and operand fetch
	// ----------------------------------------------------------------
	assign dec       = mcis_pkg::mcis_decode(instrWord);
	assign isExec    = runEnable_reg && (state_reg == mcis_pkg::ST_EXEC);
	assign fileRead  = fileMem[dec.fileAddr];
	assign bitVal    = fileRead[dec.bitSel];
	assign andResult = accumulator_reg & fileRead;
	assign fetchAddr = pc_reg;

	// ----------------------------------------------------------------
	// execute
	// ----------------------------------------------------------------
	// next state of core registers for the current word
	always_comb
	begin
		accumulator_next = accumulator_reg;
		status_next      = status_reg;
		pc_next          = pc_reg;
		state_next       = state_reg;
		fileWrEn         = 1'b0;
		fileWrData       = mcis_pkg::DATA_ZERO;
		pushEn           = 1'b0;
		watchClear       = 1'b0;
		if (runEnable_reg)
		begin
			pc_next = pc_reg + 11'h001;
			case (state_reg)
				mcis_pkg::ST_EXEC:
				begin
					case (dec.op)
						mcis_pkg::OP_AND_FILE:
						begin
							status_next[mcis_pkg::STAT_NULL_BIT] = (andResult == mcis_pkg::DATA_ZERO);
							if (dec.dest)
							begin
								fileWrEn   = 1'b1;
								fileWrData = andResult;
							end
							else
							begin
								accumulator_next = andResult;
							end
						end
						mcis_pkg::OP_TEST_CLR:
						begin
							if (!bitVal)
								state_next = mcis_pkg::ST_SKIP;
						end
						mcis_pkg::OP_TEST_SET:
						begin
							if (bitVal)
								state_next = mcis_pkg::ST_SKIP;
						end
						mcis_pkg::OP_CLR_ACC:
						begin
							accumulator_next = mcis_pkg::DATA_ZERO;
							status_next[mcis_pkg::STAT_NULL_BIT] = 1'b1;
						end
						mcis_pkg::OP_CLR_FILE:
						begin
							fileWrEn   = 1'b1;
							fileWrData = mcis_pkg::DATA_ZERO;
							status_next[mcis_pkg::STAT_NULL_BIT] = 1'b1;
						end
						mcis_pkg::OP_CALL:
						begin
							pushEn     = 1'b1;
							pc_next    = {status_reg[mcis_pkg::STAT_PAGE_HI:mcis_pkg::STAT_PAGE_LO],
								1'b0, dec.literal};
							state_next = mcis_pkg::ST_BRANCH;
						end
						mcis_pkg::OP_CLR_WATCH:
						begin
							watchClear = 1'b1;
							status_next[mcis_pkg::STAT_EXPIRY_BIT] = 1'b1;
							status_next[mcis_pkg::STAT_SLEEP_BIT]  = 1'b1;
						end
						default:
						begin
							accumulator_next = accumulator_reg;
						end
					endcase
				end
				mcis_pkg::ST_SKIP:
				begin
					state_next = mcis_pkg::ST_EXEC;
				end
				mcis_pkg::ST_BRANCH:
				begin
					pc_next    = pc_reg; // target fetched, not consumed
					state_next = mcis_pkg::ST_EXEC;
				end
				default:
				begin
					state_next = mcis_pkg::ST_EXEC;
				end
			endcase
		end
	end

	// program counter and sequencing state
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			pc_reg    <= mcis_pkg::PC_RESET;
			state_reg <= mcis_pkg::ST_EXEC;
		end
		else
		begin
			pc_reg    <= pc_next;
			state_reg <= state_next;
		end
	end

	// accumulator, core wins over software while running
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			accumulator_reg <= mcis_pkg::DATA_ZERO;
		else if (busWrite && avs_address == mcis_pkg::REG_ACC)
			accumulator_reg <= avs_writedata[7:0];
		else
			accumulator_reg <= accumulator_next;
	end

	// status register
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			status_reg <= mcis_pkg::STATUS_RESET;
		else if (busWrite && avs_address == mcis_pkg::REG_STATUS)
			status_reg <= avs_writedata[7:0];
		else
			status_reg <= status_next;
	end

	// file registers, written by the core or by software when halted
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			for (int i = 0; i < mcis_pkg::FILE_DEPTH; i++)
				fileMem[i] <= mcis_pkg::DATA_ZERO;
		end
		else if (fileWrEn)
			fileMem[dec.fileAddr] <= fileWrData;
		else if (swFileWr)
			fileMem[avs_address[6:2]] <= avs_writedata[7:0];
	end

	// hardware stack, newest entry at index zero
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			stack_reg[0] <= mcis_pkg::PC_RESET;
		else if (pushEn)
			stack_reg[0] <= pc_reg + 11'h001;
	end

	genvar gi;
	generate
		for (gi = 1; gi < mcis_pkg::STACK_DEPTH; gi++)
		begin : g_stack
			// older entries shift down on a push
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					stack_reg[gi] <= mcis_pkg::PC_RESET;
				else if (pushEn)
					stack_reg[gi] <= stack_reg[gi-1];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	// free count while running, cleared by the clear instruction
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			watchdogCounter_reg <= mcis_pkg::DATA_ZERO;
		else if (watchClear)
			watchdogCounter_reg <= mcis_pkg::DATA_ZERO;
		else if (runEnable_reg)
			watchdogCounter_reg <= watchdogCounter_reg + 8'h01;
	end

	// clear strobes toward watchdog and prescaler
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wdtClear_reg       <= 1'b0;
			prescalerClear_reg <= 1'b0;
		end
		else
		begin
			wdtClear_reg       <= watchClear;
			prescalerClear_reg <= watchClear && psaToWdt_reg;
		end
	end

	assign wdtClearPulse       = wdtClear_reg;
	assign prescalerClearPulse = prescalerClear_reg;

	// ----------------------------------------------------------------
	// avalon-mm slave
	// ----------------------------------------------------------------
	// one wait cycle, then accept
	assign busAccept       = (avs_read || avs_write) && ackPhase_reg;
	assign avs_waitrequest = (avs_read || avs_write) && !ackPhase_reg;
	assign busWrite        = busAccept && avs_write && avs_byteenable[0] && !runEnable_reg;
	assign swFileWr        = busWrite && avs_address[7] && !fileWrEn;
	assign avs_readdata    = readData_reg;

	// read mux for the register map
	function automatic logic [31:0] regRead(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == mcis_pkg::REG_CTRL)
		begin
			r[mcis_pkg::CTRL_RUN_BIT] = runEnable_reg;
			r[mcis_pkg::CTRL_PSA_BIT] = psaToWdt_reg;
		end
		else if (a == mcis_pkg::REG_STATUS)
			r[7:0] = status_reg;
		else if (a == mcis_pkg::REG_ACC)
			r[7:0] = accumulator_reg;
		else if (a == mcis_pkg::REG_PC)
			r[10:0] = pc_reg;
		else if (a == mcis_pkg::REG_WATCH)
			r[7:0] = watchdogCounter_reg;
		else if (a >= mcis_pkg::REG_FILE_BASE)
			r[7:0] = fileMem[a[6:2]];
		return r;
	endfunction

	// handshake phase and read data capture
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ackPhase_reg <= 1'b0;
			readData_reg <= 32'h0000_0000;
		end
		else
		begin
			ackPhase_reg <= (avs_read || avs_write) && !ackPhase_reg;
			if (avs_read && !ackPhase_reg)
				readData_reg <= regRead(avs_address);
		end
	end

	// control register
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			runEnable_reg <= 1'b0;
			psaToWdt_reg  <= 1'b0;
		end
		else if (busAccept && avs_write && avs_byteenable[0] && avs_address == mcis_pkg::REG_CTRL)
		begin
			runEnable_reg <= avs_writedata[mcis_pkg::CTRL_RUN_BIT];
			psaToWdt_reg  <= avs_writedata[mcis_pkg::CTRL_PSA_BIT];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_and_null;
		isExec && dec.op == mcis_pkg::OP_AND_FILE
		|=> status_reg[mcis_pkg::STAT_NULL_BIT] == ($past(andResult) == 8'h00);
	endproperty
	a_and_null: assert property (p_and_null) else $error("and null flag wrong");

	property p_and_acc;
		isExec && dec.op == mcis_pkg::OP_AND_FILE && !dec.dest
		|=> accumulator_reg == $past(andResult);
	endproperty
	a_and_acc: assert property (p_and_acc) else $error("and to accumulator wrong");

	property p_and_file;
		isExec && dec.op == mcis_pkg::OP_AND_FILE && dec.dest
		|=> fileMem[$past(dec.fileAddr)] == $past(andResult) && accumulator_reg == $past(accumulator_reg);
	endproperty
	a_and_file: assert property (p_and_file) else $error("and to file wrong");

	property p_skip_clear;
		isExec && dec.op == mcis_pkg::OP_TEST_CLR && !bitVal
		|=> state_reg == mcis_pkg::ST_SKIP ##1 state_reg == mcis_pkg::ST_EXEC;
	endproperty
	a_skip_clear: assert property (p_skip_clear) else $error("skip on clear missed");

	property p_skip_flush;
		state_reg == mcis_pkg::ST_SKIP && runEnable_reg
		|=> accumulator_reg == $past(accumulator_reg) && status_reg == $past(status_reg)
			&& pc_reg == $past(pc_reg) + 11'h001;
	endproperty
	a_skip_flush: assert property (p_skip_flush) else $error("flushed word executed");

	property p_skip_set;
		isExec && (dec.op == mcis_pkg::OP_TEST_SET || dec.op == mcis_pkg::OP_TEST_CLR)
		|=> status_reg == $past(status_reg)
			&& (state_reg == mcis_pkg::ST_SKIP) == ($past(bitVal) == ($past(dec.op) == mcis_pkg::OP_TEST_SET));
	endproperty
	a_skip_set: assert property (p_skip_set) else $error("bit test wrong");

	property p_clr_acc;
		isExec && dec.op == mcis_pkg::OP_CLR_ACC
		|=> accumulator_reg == 8'h00 && status_reg[mcis_pkg::STAT_NULL_BIT];
	endproperty
	a_clr_acc: assert property (p_clr_acc) else $error("accumulator clear wrong");

	property p_clr_file;
		isExec && dec.op == mcis_pkg::OP_CLR_FILE
		|=> fileMem[$past(dec.fileAddr)] == 8'h00 && status_reg[mcis_pkg::STAT_NULL_BIT];
	endproperty
	a_clr_file: assert property (p_clr_file) else $error("file clear wrong");

	property p_call;
		isExec && dec.op == mcis_pkg::OP_CALL
		|=> stack_reg[0] == $past(pc_reg) + 11'h001
			&& pc_reg == {$past(status_reg[6:5]), 1'b0, $past(dec.literal)}
			&& status_reg == $past(status_reg)
		##1 pc_reg == $past(pc_reg) && state_reg == mcis_pkg::ST_EXEC;
	endproperty
	a_call: assert property (p_call) else $error("call sequence wrong");

	property p_clr_watch;
		isExec && dec.op == mcis_pkg::OP_CLR_WATCH
		|=> watchdogCounter_reg == 8'h00 && wdtClearPulse
			&& prescalerClearPulse == $past(psaToWdt_reg)
			&& status_reg[mcis_pkg::STAT_EXPIRY_BIT] && status_reg[mcis_pkg::STAT_SLEEP_BIT];
	endproperty
	a_clr_watch: assert property (p_clr_watch) else $error("watchdog clear wrong");

	property p_single;
		isExec && (dec.op == mcis_pkg::OP_AND_FILE || dec.op == mcis_pkg::OP_CLR_ACC
			|| dec.op == mcis_pkg::OP_CLR_FILE || dec.op == mcis_pkg::OP_CLR_WATCH)
		|=> state_reg == mcis_pkg::ST_EXEC && pc_reg == $past(pc_reg) + 11'h001;
	endproperty
	a_single: assert property (p_single) else $error("single cycle broken");

endmodule // mcis_core

// file: testbench/mcis_prog_mem.sv
/*
 * program memory model that feeds instruction words to the core.
 * assumes: the bench loads words only while the core is halted;
 * slots that were never loaded hold the no-operation word.
 */
module mcis_prog_mem (
	input  wire logic [10:0] fetchAddr,
	output logic [11:0]      instrWord
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// storage and read port
	// ------------------------------------------------------------
	logic [11:0] mem [0:2047];

	// word for the addressed slot in the same cycle
	assign instrWord = mem[fetchAddr];
endmodule // mcis_prog_mem

// file: testbench/mcu_core_instruction_subset_tb_top.sv
/*
 * self-checking bench for the instruction subset core.
 * assumes: a 100 MHz clock, a program memory model beside the core,
 * and register access over Avalon-MM while the core is halted.
 */
module mcu_core_instruction_subset_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic        sys_clk;
	logic        reset;
	logic [10:0] fetchAddr;
	logic [11:0] instrWord;
	logic        wdtClearPulse;
	logic        prescalerClearPulse;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	int          nErrors;
	int          checksDone;
	int          wdtSeen;
	int          prescSeen;
	logic        tracing;
	logic [10:0] trace [$];
	logic [7:0]  rd;

	mcis_core i_dut (
		.sys_clk            (sys_clk),
		.reset              (reset),
		.fetchAddr          (fetchAddr),
		.instrWord          (instrWord),
		.wdtClearPulse      (wdtClearPulse),
		.prescalerClearPulse(prescalerClearPulse),
		.avs_address        (avs_address),
		.avs_read           (avs_read),
		.avs_write          (avs_write),
		.avs_writedata      (avs_writedata),
		.avs_byteenable     (avs_byteenable),
		.avs_readdata       (avs_readdata),
		.avs_waitrequest    (avs_waitrequest)
	);

	mcis_prog_mem i_mem (
		.fetchAddr(fetchAddr),
		.instrWord(instrWord)
	);

	// ------------------------------------------------------------
	// clock and monitors
	// ------------------------------------------------------------
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	// records the fetch address and counts clear pulses
	always @(posedge sys_clk)
	begin
		if (tracing)
			trace.push_back(fetchAddr);
		if (wdtClearPulse === 1'b1)
			wdtSeen++;
		if (prescalerClearPulse === 1'b1)
			prescSeen++;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_read      <= ~wr;
		avs_write     <= wr;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata[7:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
		begin
			nErrors++;
			results;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(name, {3'h0, rd}, {3'h0, exp});
	endtask

	// reset pulse, empty program, cleared monitors
	task automatic restart;
		reset <= 1'b1;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 2048; i++)
			i_mem.mem[i] = 12'h000;
		trace.delete();
		wdtSeen   = 0;
		prescSeen = 0;
	endtask

	// runs the loaded program for a while, then halts
	task automatic run(input logic psa);
		wr(8'h00, {6'h00, psa, 1'b1});
		tracing = 1'b1;
		repeat (20) @(posedge sys_clk);
		wr(8'h00, {6'h00, psa, 1'b0});
		tracing = 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// reset values, read-only and unmapped places
	task automatic t_map;
		restart;
		rdchk("status", 8'h04, 8'h18);
		rdchk("acc", 8'h08, 8'h00);
		rdchk("file31", 8'hfc, 8'h00);
		wr(8'h40, 8'h5a);
		rdchk("unmapped", 8'h40, 8'h00);
		wr(8'h0c, 8'h55);
		rdchk("pc", 8'h0c, 8'h00);
	endtask

	// and with both destinations, result used by the next one
	task automatic t_and;
		restart;
		wr(8'h04, 8'h00);
		wr(8'h08, 8'hca);
		wr(8'h8c, 8'hac);
		wr(8'h90, 8'h35);
		i_mem.mem[0] = 12'h143;
		i_mem.mem[1] = 12'h164;
		run(1'b0);
		rdchk("and acc", 8'h08, 8'h88);
		rdchk("and f3", 8'h8c, 8'hac);
		rdchk("and f4", 8'h90, 8'h00);
		rdchk("and z set", 8'h04, 8'h04);
		restart;
		wr(8'h04, 8'h04);
		wr(8'h08, 8'h88);
		wr(8'h94, 8'hf0);
		i_mem.mem[0] = 12'h165;
		run(1'b0);
		rdchk("and f5", 8'h94, 8'h80);
		rdchk("and acc kept", 8'h08, 8'h88);
		rdchk("and z clear", 8'h04, 8'h00);
	endtask

	// clearing a file register at the top address, then the accumulator
	task automatic t_clear;
		restart;
		wr(8'h04, 8'h00);
		wr(8'h08, 8'h77);
		wr(8'hfc, 8'h5a);
		i_mem.mem[0] = 12'h07f;
		run(1'b0);
		rdchk("clear_file_register f31", 8'hfc, 8'h00);
		rdchk("clear_file_register acc", 8'h08, 8'h77);
		rdchk("clear_file_register z", 8'h04, 8'h04);
		restart;
		wr(8'h04, 8'h00);
		wr(8'h08, 8'h77);
		i_mem.mem[0] = 12'h040;
		run(1'b0);
		rdchk("clear_accumulator acc", 8'h08, 8'h00);
		rdchk("clear_accumulator z", 8'h04, 8'h04);
	endtask

	// both bit tests on every bit position
	task automatic t_skip;
		logic [7:0] v;
		logic       tk;
		v = 8'ha5;
		for (int s = 0; s < 2; s++)
			for (int b = 0; b < 8; b++)
			begin
				restart;
				wr(8'h04, 8'h00);
				wr(8'h08, 8'h33);
				wr(8'h9c, v);
				i_mem.mem[0] = (s == 1 ? 12'h700 : 12'h600) | 12'(b << 5) | 12'h007;
				i_mem.mem[1] = 12'h040;
				i_mem.mem[2] = 12'h004;
				run(1'b0);
				tk = (v[b] == s[0]);
				rdchk("skip acc", 8'h08, tk ? 8'h33 : 8'h00);
				rdchk("skip status", 8'h04, tk ? 8'h18 : 8'h1c);
				check("skip next runs", 11'(wdtSeen), 11'h001);
			end
	endtask

	// calls on two pages, low and high literal
	task automatic t_call;
		logic [1:0]  pg;
		logic [7:0]  k;
		logic [10:0] t;
		int          i;
		for (int c = 0; c < 2; c++)
		begin
			pg = (c == 1) ? 2'h3 : 2'h1;
			k  = (c == 1) ? 8'hff : 8'h00;
			t  = {pg, 1'b0, k};
			restart;
			wr(8'h04, {1'b0, pg, 5'h00});
			wr(8'h08, 8'h11);
			wr(8'ha8, 8'h22);
			i_mem.mem[0] = 12'h900 | {4'h0, k};
			i_mem.mem[1] = 12'h040;
			i_mem.mem[t] = 12'h06a;
			run(1'b0);
			i = 0;
			for (int j = 0; j < trace.size(); j++)
				if (trace[j] === 11'h000)
					i = j;
			check("call target", trace[i + 1], t);
			check("call flush", trace[i + 2], t);
			check("call after", trace[i + 3], t + 11'h001);
			check("call push", i_dut.stack_reg[0], 11'h001);
			rdchk("call acc", 8'h08, 8'h11);
			rdchk("call f10", 8'ha8, 8'h00);
			rdchk("call status", 8'h04, {1'b0, pg, 5'h04});
		end
	endtask

	// watchdog clear with the prescaler on either side
	task automatic t_wdt;
		for (int p = 0; p < 2; p++)
		begin
			restart;
			wr(8'h04, 8'h00);
			i_mem.mem[10] = 12'h004;
			run(p[0]);
			check("wdt pulse", 11'(wdtSeen), 11'h001);
			check("presc pulse", 11'(prescSeen), 11'(p));
			rdchk("wdt status", 8'h04, 8'h18);
			bus(1'b0, 8'h10, 8'h00);
			check("wdt count", {10'h000, rd >= 8'h08 && rd <= 8'h10}, 11'h001);
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		reset          = 1'b1;
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'h1;
		tracing        = 1'b0;
		nErrors        = 0;
		checksDone     = 0;
		t_map;
		t_and;
		t_clear;
		t_skip;
		t_call;
		t_wdt;
		results;
	end
endmodule // mcu_core_instruction_subset_tb_top
